// [hw/capture_gate_pkg.sv]
package capture_gate_pkg;
	localparam logic [11:0] ctrl_addr    = 12'h000;
	localparam logic [11:0] cfg_addr     = 12'h004;
	localparam logic [11:0] status_addr  = 12'h008;
	localparam logic [11:0] result1_addr = 12'h00C;
	localparam logic [11:0] result2_addr = 12'h010;
	localparam logic [11:0] counter_addr = 12'h014;
	// ctrl bit positions
	localparam int en1_rise_bit = 0;
	localparam int en1_fall_bit = 1;
	localparam int en2_rise_bit = 2;
	localparam int en2_fall_bit = 3;
	// cfg bit positions
	localparam int gate_lo_bit  = 0;
	localparam int cont1_bit    = 2;
	localparam int cont2_bit    = 3;
	localparam int ovf_clr_bit  = 4;
	localparam logic [1:0] gate_off  = 2'h0;
	localparam logic [1:0] gate_high = 2'h1;
	localparam logic [1:0] gate_low  = 2'h2;
	localparam logic [15:0] diag_text_id = 16'h8315;
	localparam logic [3:0]  ctrl_reset   = 4'h0;
	localparam logic [4:0]  cfg_reset    = 5'h00;
endpackage

// [hw/counter_edge_capture_and_gate.sv]
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
module counter_edge_capture_and_gate
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	input  wire logic [31:0] counter_in,
	input  wire logic        capture_pin,
	input  wire logic        gate_pin,
	input  wire logic        encoder_status_pin,
	input  wire logic        overvoltage_pin,
	output logic             counter_hold,
	output logic             diagnostic_message,
	output logic      [15:0] diagnostic_text
);
	import capture_gate_pkg::*;

	logic [3:0]  ctrl;
	logic [4:0]  cfg;
	logic [31:0] result1;
	logic [31:0] result2;
	logic        valid1;
	logic        valid2;
	logic        input_error;
	logic        done1;
	logic        done2;
	logic [3:0]  sync_a;
	logic [3:0]  sync_b;
	logic [3:0]  prev;
	logic        cap_lvl;
	logic        gate_lvl;
	logic        enc_lvl;
	logic        ov_lvl;
	logic        rise1;
	logic        fall1;
	logic        rise2;
	logic        fall2;
	logic        ov_rise;
	logic        hit1;
	logic        hit2;
	logic [1:0]  gate_mode;
	logic        next_hold;
	logic        wr;
	logic        rd;

	// three flops per pin; logic reads stage b and the prev stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
			prev   <= 4'h0;
		end
		else
		begin
			sync_a <= {overvoltage_pin, encoder_status_pin, gate_pin,
				capture_pin};
			sync_b <= sync_a;
			prev   <= sync_b;
		end
	end

	// edges come from consecutive synchronised samples
	assign cap_lvl  = sync_b[0];
	assign gate_lvl = sync_b[1];
	assign enc_lvl  = sync_b[2];
	assign ov_lvl   = sync_b[3];
	assign rise1    = sync_b[0] & ~prev[0];
	assign fall1    = ~sync_b[0] & prev[0];
	assign rise2    = sync_b[1] & ~prev[1];
	assign fall2    = ~sync_b[1] & prev[1];
	assign ov_rise  = sync_b[3] & ~prev[3];
	assign gate_mode = cfg[1:0];

	// qualified capture events; done blocks one-shot until that channel's two enables drop
	assign hit1 = ((rise1 & ctrl[en1_rise_bit])
		| (fall1 & ctrl[en1_fall_bit]))
		& (cfg[cont1_bit] | (~done1 & ~valid1));
	assign hit2 = ((rise2 & ctrl[en2_rise_bit])
		| (fall2 & ctrl[en2_fall_bit]))
		& (cfg[cont2_bit] | (~done2 & ~valid2));

	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;

	// software registers, written at the access phase only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= ctrl_reset;
			cfg  <= cfg_reset;
		end
		else if (wr && paddr == ctrl_addr)
			ctrl <= pwdata[3:0];
		else if (wr && paddr == cfg_addr)
			cfg <= pwdata[4:0];
	end

	// capture result one; in one-shot mode first enabled event wins, later ones ignored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			result1 <= 32'h0000_0000;
			valid1  <= 1'b0;
			done1   <= 1'b0;
		end
		else if (hit1)
		begin
			result1 <= counter_in;
			valid1  <= 1'b1;
			done1   <= 1'b1;
		end
		else if (ctrl[1:0] == 2'h0 && !cfg[cont1_bit])
		begin
			valid1 <= 1'b0;
			done1  <= 1'b0;
		end
	end

	// capture result two from the gate/capture input
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			result2 <= 32'h0000_0000;
			valid2  <= 1'b0;
			done2   <= 1'b0;
		end
		else if (hit2)
		begin
			result2 <= counter_in;
			valid2  <= 1'b1;
			done2   <= 1'b1;
		end
		else if (ctrl[3:2] == 2'h0 && !cfg[cont2_bit])
		begin
			valid2 <= 1'b0;
			done2  <= 1'b0;
		end
	end

	// hold follows the synchronised level; capture above samples the
	// counter in the same cycle the hold asserts, so the value precedes it
	always_comb
	begin
		case (gate_mode)
			gate_high: next_hold = gate_lvl;
			gate_low:  next_hold = ~gate_lvl;
			default:   next_hold = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			counter_hold <= 1'b0;
		else
			counter_hold <= next_hold;
	end

	// overvoltage: sticky error flag, one-cycle diagnostic pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			input_error        <= 1'b0;
			diagnostic_message <= 1'b0;
			diagnostic_text    <= 16'h0000;
		end
		else
		begin
			diagnostic_message <= ov_rise;
			if (ov_rise)
				diagnostic_text <= diag_text_id;
			if (ov_lvl)
				input_error <= 1'b1;
			else if (wr && paddr == cfg_addr && pwdata[ovf_clr_bit])
				input_error <= 1'b0; // set wins over clear
		end
	end

	// apb read data, latched in setup so the access phase sees it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & (paddr > counter_addr
				|| paddr[1:0] != 2'h0);
			if (rd)
			begin
				case (paddr)
					ctrl_addr:    prdata <= {28'h0, ctrl};
					cfg_addr:     prdata <= {27'h00, cfg};
					status_addr:  prdata <= {25'h0, input_error,
						enc_lvl, gate_lvl, cap_lvl, counter_hold,
						valid2, valid1};
					result1_addr: prdata <= result1;
					result2_addr: prdata <= result2;
					counter_addr: prdata <= counter_in;
					default:      prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// encoder status: high or open pin reads as good (1)
	// the synchronised level is passed as-is: pin high -> bit true

	property p_capture1;
		@(posedge pclk) disable iff (!presetn)
		hit1 |=> valid1 && result1 == $past(counter_in);
	endproperty
	a_capture1: assert property (p_capture1)
		else $error("capture one not stored");

	property p_oneshot1;
		@(posedge pclk) disable iff (!presetn)
		(valid1 && !cfg[cont1_bit] && ctrl[1:0] != 2'h0)
		|=> $stable(result1);
	endproperty
	a_oneshot1: assert property (p_oneshot1)
		else $error("one-shot result one changed");

	property p_capture2;
		@(posedge pclk) disable iff (!presetn)
		hit2 |=> valid2 && result2 == $past(counter_in);
	endproperty
	a_capture2: assert property (p_capture2)
		else $error("capture two not stored");

	property p_oneshot2;
		@(posedge pclk) disable iff (!presetn)
		(valid2 && !cfg[cont2_bit] && ctrl[3:2] != 2'h0)
		|=> $stable(result2);
	endproperty
	a_oneshot2: assert property (p_oneshot2)
		else $error("one-shot result two changed");

	property p_gate_off;
		@(posedge pclk) disable iff (!presetn)
		gate_mode == gate_off |=> !counter_hold;
	endproperty
	a_gate_off: assert property (p_gate_off)
		else $error("hold while gate off");

	sequence s_gate_high_set;
		gate_mode == gate_high && gate_lvl;
	endsequence
	property p_gate_high;
		@(posedge pclk) disable iff (!presetn)
		s_gate_high_set |=> counter_hold;
	endproperty
	a_gate_high: assert property (p_gate_high)
		else $error("no hold on high gate");

	property p_continuous1;
		@(posedge pclk) disable iff (!presetn)
		(cfg[cont1_bit] && rise1 && ctrl[en1_rise_bit])
		|=> result1 == $past(counter_in);
	endproperty
	a_continuous1: assert property (p_continuous1)
		else $error("continuous capture one missed");

	property p_rearm;
		@(posedge pclk) disable iff (!presetn)
		(ctrl[1:0] == 2'h0 && !cfg[cont1_bit] && !hit1) |=> !valid1;
	endproperty
	a_rearm: assert property (p_rearm)
		else $error("valid one not cleared");

	property p_diag;
		@(posedge pclk) disable iff (!presetn)
		ov_rise |=> diagnostic_message && input_error
			&& diagnostic_text == diag_text_id;
	endproperty
	a_diag: assert property (p_diag)
		else $error("overvoltage not reported");

	// gate and capture share one edge: the count must be taken before the
	// hold reaches the counter, or the stored value would lag the edge
	sequence s_high_capture;
		gate_mode == gate_high && rise2 && hit2;
	endsequence
	property p_capture_hold_high;
		@(posedge pclk) disable iff (!presetn)
		s_high_capture
		|=> counter_hold && result2 == $past(counter_in);
	endproperty
	a_capture_hold_high: assert property (p_capture_hold_high)
		else $error("no capture before high hold");

	sequence s_low_capture;
		gate_mode == gate_low && fall2 && hit2;
	endsequence
	property p_capture_hold_low;
		@(posedge pclk) disable iff (!presetn)
		s_low_capture
		|=> counter_hold && result2 == $past(counter_in);
	endproperty
	a_capture_hold_low: assert property (p_capture_hold_low)
		else $error("no capture before low hold");

	property p_gate_low;
		@(posedge pclk) disable iff (!presetn)
		gate_mode == gate_low && !gate_lvl |=> counter_hold;
	endproperty
	a_gate_low: assert property (p_gate_low)
		else $error("no hold on low gate");

	property p_gate_release;
		@(posedge pclk) disable iff (!presetn)
		gate_mode == gate_high && !gate_lvl |=> !counter_hold;
	endproperty
	a_gate_release: assert property (p_gate_release)
		else $error("hold while high gate input low");

	// one-shot results stay frozen whatever the enables do meanwhile
	property p_accept1;
		@(posedge pclk) disable iff (!presetn)
		valid1 && !cfg[cont1_bit] |=> $stable(result1);
	endproperty
	a_accept1: assert property (p_accept1)
		else $error("result one taken while valid");

	property p_accept2;
		@(posedge pclk) disable iff (!presetn)
		valid2 && !cfg[cont2_bit] |=> $stable(result2);
	endproperty
	a_accept2: assert property (p_accept2)
		else $error("result two taken while valid");

	property p_rearm2;
		@(posedge pclk) disable iff (!presetn)
		(ctrl[3:2] == 2'h0 && !cfg[cont2_bit] && !hit2) |=> !valid2;
	endproperty
	a_rearm2: assert property (p_rearm2)
		else $error("valid two not cleared");

	property p_error_set;
		@(posedge pclk) disable iff (!presetn)
		ov_lvl |=> input_error;
	endproperty
	a_error_set: assert property (p_error_set)
		else $error("error flag low under overvoltage");
endmodule

// [tb/encoder_model.sv]
`timescale 1ns/10ps
module encoder_model
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        hold,
	input  wire logic        fault,
	output logic      [31:0] count,
	output logic             status
);
	// an open encoder output leaves the pulled-up line high
	assign status = !fault;
	// free count; it stands still only while the block asks for a hold
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			count <= 32'h0000_0100;
		else if (!hold)
			count <= count + 32'h1;
endmodule

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
	import capture_gate_pkg::*;
	typedef struct packed {logic [3:0] en; logic g; logic r; logic h;} row_t;
	logic        pclk = 1'h0;
	logic        presetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic [31:0] counter_in;
	logic        capture_pin = 1'h0;
	logic        gate_pin = 1'h0;
	logic        fault = 1'h0;
	logic        encoder_status_pin;
	logic        overvoltage_pin = 1'h0;
	logic        counter_hold;
	logic        diagnostic_message;
	logic [15:0] diagnostic_text;
	logic [31:0] rv;
	logic [31:0] c;
	logic [31:0] r1;
	logic        re;
	int          miscompares = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          n;
	// enables, pin (1 = gate pin), rising edge, capture expected
	row_t rows [8] = '{'{4'h1, 0, 1, 1}, '{4'h1, 0, 0, 0}, '{4'h2, 0, 0, 1},
		'{4'h3, 0, 0, 1}, '{4'h4, 1, 1, 1}, '{4'h8, 1, 0, 1},
		'{4'hC, 1, 1, 1}, '{4'h8, 1, 1, 0}};
	counter_edge_capture_and_gate dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.counter_in(counter_in), .capture_pin(capture_pin),
		.gate_pin(gate_pin), .encoder_status_pin(encoder_status_pin),
		.overvoltage_pin(overvoltage_pin), .counter_hold(counter_hold),
		.diagnostic_message(diagnostic_message),
		.diagnostic_text(diagnostic_text));
	encoder_model enc_u (.clk(pclk), .rst_n(presetn), .hold(counter_hold),
		.fault(fault), .count(counter_in), .status(encoder_status_pin));
	always #5 pclk = ~pclk;
	// a hang counts as a mismatch and still reaches the report
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	// pin edges need a few cycles to pass the synchronisers
	task automatic rng(input logic [31:0] got);
		chkb(got - c > 32'h0 && got - c < 32'h8, 1'h1);
	endtask
	task automatic w(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rv = prdata;
		re = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// counter value at the edge that moves the pin
	task automatic setp(input logic g, input logic v);
		@(posedge pclk);
		if (g)
			gate_pin <= v;
		else
			capture_pin <= v;
		c = counter_in;
	endtask
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, ctrl_addr, 32'h0);
		chk(rv, 32'h0);
		apb(1'h0, 12'h018, 32'h0);
		chk({re, rv[30:0]}, 32'h8000_0000);
		$display("reset and map done");
		for (n = 0; n < 8; n++)
		begin
			apb(1'h1, ctrl_addr, 32'h0);
			setp(rows[n].g, !rows[n].r);
			w(8);
			apb(1'h1, ctrl_addr, {28'h0, rows[n].en});
			setp(rows[n].g, rows[n].r);
			w(8);
			apb(1'h0, status_addr, 32'h0);
			chkb(rv[rows[n].g], rows[n].h);
			chkb(rv[3], capture_pin);
			chkb(rv[4], gate_pin);
			chkb(counter_hold, 1'h0);
			apb(1'h0, rows[n].g ? result2_addr : result1_addr, 32'h0);
			if (rows[n].h)
				rng(rv);
		end
		$display("edge table done");
		apb(1'h1, ctrl_addr, 32'h3);
		setp(1'h0, 1'h1);
		w(8);
		apb(1'h0, result1_addr, 32'h0);
		r1 = rv;
		setp(1'h0, 1'h0);
		w(8);
		apb(1'h0, result1_addr, 32'h0);
		chk(rv, r1);
		apb(1'h1, ctrl_addr, 32'h1);
		apb(1'h0, status_addr, 32'h0);
		chkb(rv[0], 1'h1);
		setp(1'h0, 1'h1);
		w(8);
		apb(1'h0, result1_addr, 32'h0);
		chk(rv, r1);
		apb(1'h1, ctrl_addr, 32'h0);
		w(4);
		apb(1'h0, status_addr, 32'h0);
		chkb(rv[0], 1'h0);
		$display("one shot done");
		apb(1'h1, cfg_addr, 32'hC);
		apb(1'h1, ctrl_addr, 32'h5);
		for (n = 0; n < 4; n++)
		begin
			setp(n[1], 1'h0);
			w(8);
			setp(n[1], 1'h1);
			w(8);
			apb(1'h0, n[1] ? result2_addr : result1_addr, 32'h0);
			rng(rv);
		end
		$display("continuous done");
		apb(1'h1, ctrl_addr, 32'h0);
		apb(1'h1, cfg_addr, {30'h0, gate_high});
		apb(1'h1, ctrl_addr, 32'h4);
		setp(1'h1, 1'h0);
		w(8);
		chkb(counter_hold, 1'h0);
		setp(1'h1, 1'h1);
		w(8);
		chkb(counter_hold, 1'h1);
		apb(1'h0, result2_addr, 32'h0);
		rng(rv);
		r1 = counter_in;
		w(4);
		chk(counter_in, r1);
		apb(1'h1, cfg_addr, {30'h0, gate_low});
		w(8);
		chkb(counter_hold, 1'h0);
		apb(1'h1, ctrl_addr, 32'h0);
		apb(1'h1, ctrl_addr, 32'h8);
		setp(1'h1, 1'h0);
		w(8);
		chkb(counter_hold, 1'h1);
		apb(1'h0, result2_addr, 32'h0);
		rng(rv);
		apb(1'h1, cfg_addr, 32'h0);
		$display("gate done");
		fault <= 1'h1;
		w(8);
		apb(1'h0, status_addr, 32'h0);
		chkb(rv[5], 1'h0);
		fault <= 1'h0;
		w(8);
		apb(1'h0, status_addr, 32'h0);
		chkb(rv[5], 1'h1);
		overvoltage_pin <= 1'h1;
		r1 = 32'h0;
		repeat (10)
		begin
			@(posedge pclk);
			r1 = r1 + {31'h0, diagnostic_message};
		end
		chk(r1, 32'h1);
		chk({16'h0, diagnostic_text}, {16'h0, diag_text_id});
		apb(1'h0, status_addr, 32'h0);
		chkb(rv[6], 1'h1);
		apb(1'h1, cfg_addr, 32'h10);
		apb(1'h0, status_addr, 32'h0);
		chkb(rv[6], 1'h1);
		overvoltage_pin <= 1'h0;
		w(8);
		apb(1'h1, cfg_addr, 32'h10);
		apb(1'h0, status_addr, 32'h0);
		chkb(rv[6], 1'h0);
		$display("status input done");
		apb(1'h1, ctrl_addr, 32'hF);
		presetn <= 1'h0;
		w(2);
		chk({16'h0, diagnostic_text}, 32'h0);
		presetn <= 1'h1;
		apb(1'h0, ctrl_addr, 32'h0);
		chk(rv, {28'h0, ctrl_reset});
		apb(1'h0, status_addr, 32'h0);
		chk({29'h0, rv[2:0]}, 32'h0);
		$display("mid-run reset done");
		wrap_up();
	end
endmodule
